// ==== smc_cfg.svh ====
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

`define SMC_ADDR_W 20
`define SMC_OFF_PWR0 20'h40400
`define SMC_OFF_DET 20'h40408
`define SMC_OFF_BOR 20'h4040c
`define SMC_OFF_FLAGS 20'h40410

`define SMC_B_LOWPWR 0
`define SMC_B_CMOUT 1
`define SMC_B_PGOOD 8
`define SMC_B_OVOLT 9

`define SMC_B_DET_ON 0
`define SMC_B_DET_INSEL 1
`define SMC_B_DET_REFSEL 2
`define SMC_B_DET_EDGE 3
`define SMC_B_LVL_LO 4
`define SMC_B_LVL_HI 7
`define SMC_B_DET_OUT 16

`define SMC_B_BOR_ON 0
`define SMC_B_BOR_ACT 1
`define SMC_B_BOR_LIVE 2
`define SMC_B_BOR_REARM 3
`define SMC_B_BLVL_LO 4
`define SMC_B_BLVL_HI 6

`define SMC_B_F_DET 0
`define SMC_B_F_BOR 1

`define SMC_DET_LVL_OFF 4'h0
`define SMC_DET_LVL_EXT 4'hf
`define SMC_BOR_LVL_RST 3'h0
`define SMC_RST_ON 1'b1
`define SMC_RST_ACT 1'b1
`define SMC_RST_REARM 1'b1

`endif

// ==== smc_pkg.sv ====
package smc_pkg;
    typedef struct packed {
        logic lowpower;
        logic cm_out_en;
    } smc_pwr_t;

    typedef struct packed {
        logic [3:0] level;
        logic edge_rise;
        logic ref_bandgap;
        logic input_display;
        logic on;
    } smc_det_t;

    typedef struct packed {
        logic [2:0] level;
        logic rearm;
        logic act_reset;
        logic on;
    } smc_bor_t;

    typedef enum logic [1:0] {
        SMC_SRC_MAIN,
        SMC_SRC_DISPLAY,
        SMC_SRC_EXTERNAL
    } smc_src_t;
endpackage

// ==== smc_top.sv ====
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_top #(
    parameter int ADDR_W = `SMC_ADDR_W
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_primary_brownout,
    input wire logic i_wake,
    input wire logic i_detector_cmp,
    input wire logic i_secondary_brownout_cmp,
    input wire logic i_core_regulator_good,
    input wire logic i_core_regulator_overvolt,
    output logic o_common_mode_out_enable,
    output logic o_core_regulator_lowpower,
    output logic o_detector_on,
    output logic [3:0] o_detector_level,
    output logic o_detector_ref_bandgap,
    output logic [1:0] o_detector_source,
    output logic o_detector_irq,
    output logic o_secondary_brownout_on,
    output logic [2:0] o_secondary_brownout_level,
    output logic o_secondary_brownout_irq,
    output logic o_chip_reset_req
);
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic rst_n;

    // Release is synchronised so every flop leaves reset on the same edge;
    // assertion stays asynchronous so a stopped clock still resets the block
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    smc_pkg::smc_pwr_t pwr_reg, pwr_next;
    smc_pkg::smc_det_t det_reg, det_next;
    smc_pkg::smc_bor_t bor_reg, bor_next;
    logic det_cmp_reg, det_cmp_next;
    logic det_flag_reg, det_flag_next;
    logic bor_flag_reg, bor_flag_next;
    logic reset_req_reg, reset_req_next;
    logic [31:0] rdata_reg, rdata_next;
    logic live_reg, live_next;
    logic pg_reg, pg_next;
    logic ov_reg, ov_next;
    logic det_edge;
    logic bor_trip;
    logic [1:0] src_reg, src_next;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    function automatic smc_pkg::smc_src_t src_of(input smc_pkg::smc_det_t d);
        if (d.level == `SMC_DET_LVL_EXT) begin
            src_of = smc_pkg::SMC_SRC_EXTERNAL;
        end else if (d.input_display) begin
            src_of = smc_pkg::SMC_SRC_DISPLAY;
        end else begin
            src_of = smc_pkg::SMC_SRC_MAIN;
        end
    endfunction

    // Edge seen only while enabled and detector level is not off
    always_comb begin
        det_edge = 1'b0;
        if (det_reg.on && det_reg.level != `SMC_DET_LVL_OFF) begin
            if (det_reg.edge_rise) begin
                det_edge = !det_cmp_reg && i_detector_cmp;
            end else begin
                det_edge = det_cmp_reg && !i_detector_cmp;
            end
        end
    end

    // Trip is the monitor going low while enabled
    assign bor_trip = bor_reg.on && live_reg && !i_secondary_brownout_cmp;

    // Low-power is a plain software bit; nothing here clears it on wake
    always_comb begin
        pwr_next = pwr_reg;
        if (i_wr && hit(i_addr, `SMC_OFF_PWR0)) begin
            pwr_next.lowpower = i_wdata[`SMC_B_LOWPWR];
            pwr_next.cm_out_en = i_wdata[`SMC_B_CMOUT];
        end
    end

    // Settings may change while enabled; software is expected to enable last
    always_comb begin
        det_next = det_reg;
        if (i_wr && hit(i_addr, `SMC_OFF_DET)) begin
            det_next.on = i_wdata[`SMC_B_DET_ON];
            det_next.input_display = i_wdata[`SMC_B_DET_INSEL];
            det_next.ref_bandgap = i_wdata[`SMC_B_DET_REFSEL];
            det_next.edge_rise = i_wdata[`SMC_B_DET_EDGE];
            det_next.level = i_wdata[`SMC_B_LVL_HI:`SMC_B_LVL_LO];
        end
    end

    // Primary brown-out is applied last so it overrides both a write and a wake
    always_comb begin
        bor_next = bor_reg;
        if (i_wr && hit(i_addr, `SMC_OFF_BOR)) begin
            bor_next.on = i_wdata[`SMC_B_BOR_ON];
            bor_next.act_reset = i_wdata[`SMC_B_BOR_ACT];
            bor_next.rearm = i_wdata[`SMC_B_BOR_REARM];
            bor_next.level = i_wdata[`SMC_B_BLVL_HI:`SMC_B_BLVL_LO];
        end
        // Wake re-arm forces reset mode even if software had chosen interrupt mode
        if (i_wake && bor_reg.rearm) begin
            bor_next.on = 1'b1;
            bor_next.act_reset = 1'b1;
        end
        if (i_primary_brownout) begin
            bor_next.level = `SMC_BOR_LVL_RST;
            bor_next.on = 1'b1;
            bor_next.act_reset = 1'b1;
        end
    end

    // Flags are write-one-to-clear; a set in the same cycle wins over the clear
    always_comb begin
        det_flag_next = det_flag_reg;
        bor_flag_next = bor_flag_reg;
        reset_req_next = 1'b0;
        if (i_wr && hit(i_addr, `SMC_OFF_FLAGS)) begin
            if (i_wdata[`SMC_B_F_DET]) begin
                det_flag_next = 1'b0;
            end
            if (i_wdata[`SMC_B_F_BOR]) begin
                bor_flag_next = 1'b0;
            end
        end
        if (det_edge) begin
            det_flag_next = 1'b1;
        end
        if (bor_trip) begin
            if (bor_reg.act_reset) begin
                // One cycle only: live follows the pin, so a trip lasts one cycle
                reset_req_next = 1'b1;
            end else begin
                bor_flag_next = 1'b1;
            end
        end
    end

    // The compare sample keeps tracking while the detector is off, so enabling
    // compares against a fresh value and never fires on a stale one
    always_comb begin
        det_cmp_next = i_detector_cmp;
        live_next = i_secondary_brownout_cmp;
        pg_next = i_core_regulator_good;
        ov_next = i_core_regulator_overvolt;
    end

    // Source follows the next settings so it changes together with the registers
    always_comb begin
        src_next = src_of(det_next);
    end

    always_comb begin
        rdata_next = 32'h0;
        if (i_rd) begin
            if (hit(i_addr, `SMC_OFF_PWR0)) begin
                rdata_next[`SMC_B_LOWPWR] = pwr_reg.lowpower;
                rdata_next[`SMC_B_CMOUT] = pwr_reg.cm_out_en;
                // Flags masked while regulator is in low-power mode
                rdata_next[`SMC_B_PGOOD] = pg_reg && !pwr_reg.lowpower;
                rdata_next[`SMC_B_OVOLT] = ov_reg && !pwr_reg.lowpower;
            end else if (hit(i_addr, `SMC_OFF_DET)) begin
                rdata_next[`SMC_B_DET_ON] = det_reg.on;
                rdata_next[`SMC_B_DET_INSEL] = det_reg.input_display;
                rdata_next[`SMC_B_DET_REFSEL] = det_reg.ref_bandgap;
                rdata_next[`SMC_B_DET_EDGE] = det_reg.edge_rise;
                rdata_next[`SMC_B_LVL_HI:`SMC_B_LVL_LO] = det_reg.level;
                rdata_next[`SMC_B_DET_OUT] = det_cmp_reg;
            end else if (hit(i_addr, `SMC_OFF_BOR)) begin
                rdata_next[`SMC_B_BOR_ON] = bor_reg.on;
                rdata_next[`SMC_B_BOR_ACT] = bor_reg.act_reset;
                rdata_next[`SMC_B_BOR_LIVE] = live_reg;
                rdata_next[`SMC_B_BOR_REARM] = bor_reg.rearm;
                rdata_next[`SMC_B_BLVL_HI:`SMC_B_BLVL_LO] = bor_reg.level;
            end else if (hit(i_addr, `SMC_OFF_FLAGS)) begin
                rdata_next[`SMC_B_F_DET] = det_flag_reg;
                rdata_next[`SMC_B_F_BOR] = bor_flag_reg;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= '0;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // Cleared on reset: the detector starts disabled with its level off
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            det_reg <= '0;
        end else begin
            det_reg <= det_next;
        end
    end

    // The monitor leaves reset armed, in reset mode, at its lowest level
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bor_reg.level <= `SMC_BOR_LVL_RST;
            bor_reg.rearm <= `SMC_RST_REARM;
            bor_reg.act_reset <= `SMC_RST_ACT;
            bor_reg.on <= `SMC_RST_ON;
        end else begin
            bor_reg <= bor_next;
        end
    end

    // The reset request is a bare pulse; chip-level reset logic must stretch it
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            det_flag_reg <= 1'b0;
            bor_flag_reg <= 1'b0;
            reset_req_reg <= 1'b0;
        end else begin
            det_flag_reg <= det_flag_next;
            bor_flag_reg <= bor_flag_next;
            reset_req_reg <= reset_req_next;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            det_cmp_reg <= 1'b0;
            live_reg <= 1'b0;
            pg_reg <= 1'b0;
            ov_reg <= 1'b0;
        end else begin
            det_cmp_reg <= det_cmp_next;
            live_reg <= live_next;
            pg_reg <= pg_next;
            ov_reg <= ov_next;
        end
    end

    // Read data drops to zero outside its slot so a stale word never lingers
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_reg <= 2'h0;
        end else begin
            src_reg <= src_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_common_mode_out_enable = pwr_reg.cm_out_en;
    assign o_core_regulator_lowpower = pwr_reg.lowpower;
    assign o_detector_on = det_reg.on;
    assign o_detector_level = det_reg.level;
    assign o_detector_ref_bandgap = det_reg.ref_bandgap;
    assign o_detector_source = src_reg;
    assign o_detector_irq = det_flag_reg;
    assign o_secondary_brownout_on = bor_reg.on;
    assign o_secondary_brownout_level = bor_reg.level;
    assign o_secondary_brownout_irq = bor_flag_reg;
    assign o_chip_reset_req = reset_req_reg;
endmodule // smc_top

// ==== smc_top_checker.sv ====
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_chk #(
    parameter int ADDR_W = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_primary_brownout,
    input wire logic i_secondary_brownout_cmp,
    input wire logic o_common_mode_out_enable,
    input wire logic o_detector_on,
    input wire logic [3:0] o_detector_level,
    input wire logic [1:0] o_detector_source,
    input wire logic o_detector_irq,
    input wire logic o_secondary_brownout_on,
    input wire logic [2:0] o_secondary_brownout_level,
    input wire logic o_secondary_brownout_irq,
    input wire logic o_chip_reset_req
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside its slot");
    AST_CM_OUT: assert property (i_wr && i_addr == `SMC_OFF_PWR0
        |=> o_common_mode_out_enable == $past(i_wdata[`SMC_B_CMOUT])) else $error("cm enable");
    AST_PBO_LVL: assert property (i_primary_brownout
        |-> ##[1:2] o_secondary_brownout_level == 3'h0) else $error("level not cleared");
    AST_PBO_ON: assert property (i_primary_brownout |=> o_secondary_brownout_on)
        else $error("monitor not forced on");
    AST_SRC_EXT: assert property (o_detector_level == `SMC_DET_LVL_EXT
        |-> o_detector_source == smc_pkg::SMC_SRC_EXTERNAL) else $error("source");
    AST_RST_PULSE: assert property (o_chip_reset_req |=> !o_chip_reset_req)
        else $error("reset request too long");
    AST_BOR_QUIET: assert property (!o_secondary_brownout_on
        |=> !o_chip_reset_req && !$rose(o_secondary_brownout_irq)) else $error("trip off");
    AST_DET_QUIET: assert property (!o_detector_on && !o_detector_irq
        |=> !o_detector_irq) else $error("detector flag while off");
    AST_DET_HOLD: assert property (o_detector_irq && !i_wr |=> o_detector_irq)
        else $error("detector flag dropped");
    cover property (o_detector_irq);
    cover property (o_secondary_brownout_irq);
    cover property (o_chip_reset_req);
endmodule // smc_chk

bind smc_top smc_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ==== smc_analog_model.sv ====
`timescale 1ns/1ps
module smc_analog_model (
    input wire logic i_clk,
    input wire logic [7:0] i_supply,
    input wire logic [3:0] i_det_level,
    input wire logic [2:0] i_bor_level,
    input wire logic i_lowpower,
    output logic o_det_cmp,
    output logic o_bor_cmp,
    output logic o_good,
    output logic o_ovolt
);
    logic tgl = 1'b0;
    always @(posedge i_clk) tgl <= ~tgl;
    assign o_det_cmp = i_supply > {i_det_level, 4'h0};
    assign o_bor_cmp = i_supply > {i_bor_level, 5'h0};
    // Flags carry no meaning in low power, so they churn rather than hold
    assign o_good = i_lowpower ? tgl : 1'b1;
    assign o_ovolt = i_lowpower ? ~tgl : 1'b0;
endmodule // smc_analog_model

// ==== smc_top_bench.sv ====
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_top_bench;
    logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_wake = 1'b0;
    logic i_primary_brownout = 1'b0, i_detector_cmp, i_secondary_brownout_cmp;
    logic i_core_regulator_good, i_core_regulator_overvolt, o_common_mode_out_enable;
    logic o_core_regulator_lowpower, o_detector_on, o_detector_ref_bandgap, o_detector_irq;
    logic o_secondary_brownout_on, o_secondary_brownout_irq, o_chip_reset_req;
    logic [19:0] i_addr = 20'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, got;
    logic [3:0] o_detector_level;
    logic [2:0] o_secondary_brownout_level;
    logic [1:0] o_detector_source;
    logic [7:0] supply = 8'hff;
    int err_count = 0, checks = 0, n;
    typedef struct {logic [19:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} smc_row_t;
    smc_row_t rows [5] = '{'{`SMC_OFF_PWR0, 32'h3, 32'h303, 32'h3},
        '{`SMC_OFF_PWR0, 32'h2, 32'h303, 32'h102}, '{`SMC_OFF_DET, 32'hf6, 32'hff, 32'hf6},
        '{`SMC_OFF_BOR, 32'h50, 32'h7b, 32'h50}, '{20'h40404, 32'hff, 32'hffffffff, 32'h0}};
    logic [31:0] sw [3] = '{32'h70, 32'h8, 32'h0};
    logic [31:0] ex [3] = '{32'h7, 32'hf, 32'h4};
    always #5 i_clk_sys = ~i_clk_sys;
    smc_top uut (.*);
    smc_analog_model far (.i_clk(i_clk_sys), .i_supply(supply), .i_det_level(o_detector_level),
        .i_bor_level(o_secondary_brownout_level), .i_lowpower(o_core_regulator_lowpower),
        .o_det_cmp(i_detector_cmp), .o_bor_cmp(i_secondary_brownout_cmp),
        .o_good(i_core_regulator_good), .o_ovolt(i_core_regulator_overvolt));
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr_reg(input logic [19:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task rd_reg(input logic [19:0] a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 got = o_rdata;
    endtask
    // Flags are polled a step after the edge so a one-cycle pulse is never missed
    task await(input int w);
        logic [2:0] v;
        for (n = 0; n < 20; n++) begin
            v = {o_chip_reset_req, o_secondary_brownout_irq, o_detector_irq};
            if (v[w] === 1'b1) break;
            @(posedge i_clk_sys);
            #1;
        end
        if (n == 20) begin
            chk("wait bound", 32'h1, 32'h0);
            report_and_stop;
        end
    endtask
    task restart;
        @(posedge i_clk_sys);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
    endtask
    initial begin
        repeat (14) @(posedge i_clk_sys);
        restart;
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a);
            chk("register row", rows[i].e, got & rows[i].m);
        end
        chk("pins", 32'h1, {30'h0, o_core_regulator_lowpower, o_common_mode_out_enable});
        $display("register rows done");
        restart;
        rd_reg(`SMC_OFF_BOR);
        chk("bor reset", 32'hf, got & 32'h7f);
        rd_reg(`SMC_OFF_DET);
        chk("det reset", 32'h10000, got & 32'h100ff);
        for (int i = 0; i < 3; i++) begin
            wr_reg(`SMC_OFF_BOR, sw[i]);
            @(posedge i_clk_sys);
            if (i == 0) i_primary_brownout <= 1'b1;
            else i_wake <= 1'b1;
            @(posedge i_clk_sys);
            i_primary_brownout <= 1'b0;
            i_wake <= 1'b0;
            rd_reg(`SMC_OFF_BOR);
            chk("bor event", ex[i], got & 32'h7f);
            chk("bor pins", ex[i] & 32'h71,
                {25'h0, o_secondary_brownout_level, 3'h0, o_secondary_brownout_on});
        end
        $display("reset and events done");
        for (int i = 0; i < 2; i++) begin
            wr_reg(`SMC_OFF_BOR, i ? 32'h3 : 32'h1);
            @(posedge i_clk_sys);
            supply <= 8'h0;
            await(i + 1);
            if (i == 0) wr_reg(`SMC_OFF_FLAGS, 32'h2);
            @(posedge i_clk_sys);
            supply <= 8'hff;
            repeat (3) @(posedge i_clk_sys);
        end
        rd_reg(`SMC_OFF_FLAGS);
        chk("flags after trips", 32'h0, got & 32'h3);
        $display("secondary trips done");
        wr_reg(`SMC_OFF_DET, 32'h10);
        supply <= 8'h0;
        repeat (3) @(posedge i_clk_sys);
        supply <= 8'hff;
        repeat (3) @(posedge i_clk_sys);
        #1 chk("detector off", 32'h0, {31'h0, o_detector_irq});
        for (int e = 0; e < 2; e++) begin
            @(posedge i_clk_sys);
            supply <= e ? 8'hff : 8'h0;
            repeat (3) @(posedge i_clk_sys);
            wr_reg(`SMC_OFF_DET, e ? 32'h18 : 32'h10);
            wr_reg(`SMC_OFF_DET, e ? 32'h19 : 32'h11);
            @(posedge i_clk_sys);
            supply <= ~supply;
            repeat (3) @(posedge i_clk_sys);
            #1 chk("wrong edge", 32'h0, {31'h0, o_detector_irq});
            supply <= ~supply;
            await(0);
            rd_reg(`SMC_OFF_DET);
            chk("det compare", e ? 32'h10019 : 32'h11, got & 32'h100ff);
            chk("det on pin", 32'h1, {31'h0, o_detector_on});
            wr_reg(`SMC_OFF_FLAGS, 32'h1);
            wr_reg(`SMC_OFF_DET, 32'h10);
        end
        wr_reg(`SMC_OFF_DET, 32'hf0);
        @(posedge i_clk_sys);
        #1 chk("source external", 32'h2f, {26'h0, o_detector_source, o_detector_level});
        wr_reg(`SMC_OFF_DET, 32'h16);
        @(posedge i_clk_sys);
        #1 chk("source display", 32'h3, {29'h0, o_detector_source, o_detector_ref_bandgap});
        $display("detector done");
        report_and_stop;
    end
endmodule // smc_top_bench
